/* File: src/rlt_consts.svh */
// Constants for the serial-port loopback tester.
`ifndef RLT_CONSTS_SVH
`define RLT_CONSTS_SVH
`define RLT_ADDR_W 8
`define RLT_DATA_W 16
`define RLT_CTRL_ADDR 8'h0A
`define RLT_CTRL_EN_BIT 0
`define RLT_CTRL_DIR_BIT 1
`define RLT_STAT_FAIL_BIT 0
`define RLT_CLK_HZ 200000000
`define RLT_LINE_BPS 1000000
`define RLT_BIT_CYCLES (`RLT_CLK_HZ / `RLT_LINE_BPS)
`define RLT_DATA_BITS 8
`endif

/* File: src/rlt_pkg.sv */
// Types for the serial-port loopback tester.
package rlt_pkg;
    typedef struct packed {
        logic line_tx;
        logic driver_enable;
        logic receiver_enable_n;
    } rlt_port_out_t;
    typedef enum logic [1:0] {
        RLT_IDLE,
        RLT_SEND,
        RLT_WAIT,
        RLT_CHECK
    } rlt_state_t;
endpackage : rlt_pkg

/* File: src/rlt_uart_tx.sv */
// Serial byte transmitter, 8N1, least significant bit first.
`timescale 1ns/1ps
`include "rlt_consts.svh"
module rlt_uart_tx import rlt_pkg::*; #(
    parameter int BIT_CYCLES = `RLT_BIT_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [7:0] data_in,
    output logic line_out,
    output logic busy_out
);
    logic [9:0] shift_q;
    logic [3:0] bits_q;
    logic [15:0] cnt_q;
    wire bit_end = (cnt_q == 16'(BIT_CYCLES - 1));
    assign busy_out = (bits_q != 4'h0);
    assign line_out = busy_out ? shift_q[0] : 1'b1;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= 10'h3FF;
            bits_q <= 4'h0;
            cnt_q <= 16'h0000;
        end else if (abort_in) begin
            // A cut frame must not resume on the line once the test is enabled again.
            shift_q <= 10'h3FF;
            bits_q <= 4'h0;
            cnt_q <= 16'h0000;
        end else if (!busy_out) begin
            cnt_q <= 16'h0000;
            if (start_in) begin
                shift_q <= {1'b1, data_in, 1'b0};
                bits_q <= 4'hA;
            end
        end else if (bit_end) begin
            cnt_q <= 16'h0000;
            shift_q <= {1'b1, shift_q[9:1]};
            bits_q <= bits_q - 4'h1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : rlt_uart_tx

/* File: src/rlt_uart_rx.sv */
// Serial byte receiver, 8N1, samples at bit centre.
`timescale 1ns/1ps
`include "rlt_consts.svh"
module rlt_uart_rx import rlt_pkg::*; #(
    parameter int BIT_CYCLES = `RLT_BIT_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic line_in,
    output logic [7:0] data_out,
    output logic valid_out
);
    logic [7:0] shift_q;
    logic [3:0] bits_q;
    logic [15:0] cnt_q;
    wire active = (bits_q != 4'h0);
    wire sample = (cnt_q == 16'(BIT_CYCLES - 1));
    wire half = (cnt_q == 16'(BIT_CYCLES / 2 - 1));
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= 8'h00;
            bits_q <= 4'h0;
            cnt_q <= 16'h0000;
            data_out <= 8'h00;
            valid_out <= 1'b0;
        end else begin
            valid_out <= 1'b0;
            if (!enable_in) begin
                // A frame cut by a disable must not report a stale byte later.
                bits_q <= 4'h0;
                cnt_q <= 16'h0000;
            end else if (!active) begin
                // Start bit is rechecked at mid-bit so a glitch is ignored.
                if (enable_in && !line_in) begin
                    if (half) begin
                        bits_q <= 4'h9;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end else begin
                    cnt_q <= 16'h0000;
                end
            end else if (sample) begin
                cnt_q <= 16'h0000;
                bits_q <= bits_q - 4'h1;
                if (bits_q == 4'h1) begin
                    data_out <= shift_q;
                    valid_out <= 1'b1;
                end else begin
                    shift_q <= {line_in, shift_q[7:1]};
                end
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule : rlt_uart_rx

/* File: src/rlt_loopback_tester.sv */
// Loopback tester driving two half-duplex serial line ports.
// Behaviour
// (R01) Test runs only while enable is set; idle otherwise.
// (R02) Direction 0 sends on port 0, direction 1 sends on port 1.
// (R03) After sending, wait for a received byte and compare it.
// (R04) After each compare, increment the test byte and repeat.
// (R05) A mismatch sets the fail flag, which stays set.
// (R06) Fail clears only when enable goes 0 then back to 1.
// (R07) Testing repeats indefinitely while enable stays set.
// (R08) Line rate is 1 Mbit/s.
// (R09) Software writes enable bit 0, direction bit 1 at address 0x0A.
// (R10) Reading address 0x0A returns fail flag in bit 0.
// (R11) Drive enable on sending port, receive enable on opposite port.
// (R12) Frames are start bit, 8 data bits LSB first, stop bit.
`timescale 1ns/1ps
`include "rlt_consts.svh"
module rlt_loopback_tester import rlt_pkg::*; #(
    parameter int BIT_CYCLES = `RLT_BIT_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [`RLT_ADDR_W-1:0] addr_in,
    input wire logic [`RLT_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [`RLT_DATA_W-1:0] rdata_out,
    output logic port0_line_tx_out,
    output logic port0_driver_enable_out,
    output logic port0_receiver_enable_n_out,
    input wire logic port0_line_rx_in,
    output logic port1_line_tx_out,
    output logic port1_driver_enable_out,
    output logic port1_receiver_enable_n_out,
    input wire logic port1_line_rx_in
);
    logic enable_q;
    logic dir_q;
    logic dir_run_q;
    logic fail_q;
    logic fail_d;
    logic [7:0] tx_byte_q;
    logic [7:0] tx_byte_d;
    rlt_state_t state_q;
    rlt_state_t state_d;
    logic tx_line;
    logic tx_busy;
    logic [7:0] rx_byte;
    logic rx_valid;
    rlt_port_out_t port0;
    rlt_port_out_t port1;

    wire ctrl_hit = (addr_in == `RLT_CTRL_ADDR);
    wire ctrl_wr = wr_in && ctrl_hit;
    wire [`RLT_DATA_W-1:0] rd_word = ctrl_hit ? {15'h0000, fail_q} : 16'h0000; // [R10]
    wire start_tx = (state_q == RLT_SEND) && !tx_busy;
    // Direction is held per byte so a mid-byte change cannot split a frame.
    wire rx_line = dir_run_q ? port0_line_rx_in : port1_line_rx_in; // [R11]
    wire running = (state_q != RLT_IDLE);
    wire tx_abort = !enable_q; // [R01]
    // Loading while idle puts the first byte's enables on the chosen port.
    wire dir_load = start_tx || !running; // [R02]

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (ctrl_wr) begin
            enable_q <= wdata_in[`RLT_CTRL_EN_BIT]; // [R09]
            dir_q <= wdata_in[`RLT_CTRL_DIR_BIT]; // [R09]
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            rdata_out <= rd_word;
        end else begin
            rdata_out <= 16'h0000;
        end
    end

    always_comb begin
        state_d = state_q;
        tx_byte_d = tx_byte_q;
        fail_d = fail_q;
        unique case (state_q)
            RLT_IDLE: begin
                if (enable_q) begin
                    state_d = RLT_SEND; // [R01]
                    fail_d = 1'b0; // [R06]
                end
            end
            RLT_SEND: begin
                if (start_tx) begin
                    state_d = RLT_WAIT; // [R02]
                end
            end
            RLT_WAIT: begin
                if (rx_valid) begin
                    state_d = RLT_CHECK; // [R03]
                end
            end
            RLT_CHECK: begin
                if (rx_byte != tx_byte_q) begin
                    fail_d = 1'b1; // [R05]
                end
                tx_byte_d = tx_byte_q + 8'h01; // [R04]
                state_d = RLT_SEND; // [R07]
            end
        endcase
        if (!enable_q) begin
            state_d = RLT_IDLE; // [R01]
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= RLT_IDLE;
            tx_byte_q <= 8'h00;
            fail_q <= 1'b0;
            dir_run_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tx_byte_q <= tx_byte_d;
            fail_q <= fail_d;
            if (dir_load) begin
                dir_run_q <= dir_q; // [R02]
            end
        end
    end

    // Drivers stay off when idle so the lines float to the idle state.
    always_comb begin
        port0.line_tx = (running && !dir_run_q) ? tx_line : 1'b1;
        port0.driver_enable = running && !dir_run_q; // [R11]
        port0.receiver_enable_n = !(running && dir_run_q); // [R11]
        port1.line_tx = (running && dir_run_q) ? tx_line : 1'b1;
        port1.driver_enable = running && dir_run_q; // [R11]
        port1.receiver_enable_n = !(running && !dir_run_q); // [R11]
    end
    assign port0_line_tx_out = port0.line_tx;
    assign port0_driver_enable_out = port0.driver_enable;
    assign port0_receiver_enable_n_out = port0.receiver_enable_n;
    assign port1_line_tx_out = port1.line_tx;
    assign port1_driver_enable_out = port1.driver_enable;
    assign port1_receiver_enable_n_out = port1.receiver_enable_n;

    rlt_uart_tx #(
        .BIT_CYCLES(BIT_CYCLES) // [R08]
    ) u_tx (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .start_in(start_tx),
        .abort_in(tx_abort),
        .data_in(tx_byte_q), // [R12]
        .line_out(tx_line),
        .busy_out(tx_busy)
    );

    rlt_uart_rx #(
        .BIT_CYCLES(BIT_CYCLES) // [R08]
    ) u_rx (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(state_q == RLT_WAIT || state_q == RLT_SEND),
        .line_in(rx_line), // [R12]
        .data_out(rx_byte),
        .valid_out(rx_valid)
    );
endmodule : rlt_loopback_tester

/* File: tb/rlt_loopback_monitor.sv */
// Port-level checker for the loopback tester.
`timescale 1ns/1ps
`include "rlt_consts.svh"
module rlt_loopback_monitor #(
    parameter int BIT_CYCLES = `RLT_BIT_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [`RLT_ADDR_W-1:0] addr_in,
    input wire logic [`RLT_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [`RLT_DATA_W-1:0] rdata_out,
    input wire logic port0_line_tx_out,
    input wire logic port0_driver_enable_out,
    input wire logic port0_receiver_enable_n_out,
    input wire logic port0_line_rx_in,
    input wire logic port1_line_tx_out,
    input wire logic port1_driver_enable_out,
    input wire logic port1_receiver_enable_n_out,
    input wire logic port1_line_rx_in
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    wire ctl_wr = wr_in && addr_in == `RLT_CTRL_ADDR;
    wire idle = !port0_driver_enable_out && !port1_driver_enable_out;
    a_read_unmapped_zero: assert property (
        rd_in && addr_in != `RLT_CTRL_ADDR |=> rdata_out == 16'h0000) else $error("bad read");
    a_rdata_quiet_zero: assert property (
        !rd_in |=> rdata_out == 16'h0000) else $error("rdata not quiet");
    a_drivers_exclusive: assert property (
        !(port0_driver_enable_out && port1_driver_enable_out)) else $error("two drivers");
    a_port0_pairing: assert property (
        port0_driver_enable_out |-> port0_receiver_enable_n_out && !port1_receiver_enable_n_out)
        else $error("port0 pairing");
    a_port1_pairing: assert property (
        port1_driver_enable_out |-> port1_receiver_enable_n_out && !port0_receiver_enable_n_out)
        else $error("port1 pairing");
    a_start_dir_zero: assert property (
        ctl_wr && wdata_in[1:0] == 2'h1 && idle |=> ##1 port0_driver_enable_out
        ##1 !port0_line_tx_out) else $error("no start");
    a_stop_on_disable: assert property (
        ctl_wr && !wdata_in[0] |=> ##1 idle) else $error("no stop");
    // The hold count assumes BIT_CYCLES of 8, the value the bench uses.
    a_bit_hold_time: assert property (
        $changed(port0_line_tx_out) && port0_driver_enable_out
        |=> ($stable(port0_line_tx_out) || !port0_driver_enable_out) [*7]) else $error("short bit");
    c_enable: cover property (ctl_wr && wdata_in[0]);
    c_port1_start: cover property (port1_driver_enable_out && $fell(port1_line_tx_out));
    c_fail_read: cover property (rd_in ##1 rdata_out[0]);
endmodule : rlt_loopback_monitor
bind rlt_loopback_tester rlt_loopback_monitor #(.BIT_CYCLES(BIT_CYCLES)) u_mon (.*);

/* File: tb/rlt_cable_model.sv */
// Two line transceivers joined by a cable, with a switch that flips data bit 0.
`timescale 1ns/1ps
module rlt_cable_model #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clock_in,
    input wire logic tx0_in,
    input wire logic de0_in,
    input wire logic ren0_n_in,
    input wire logic tx1_in,
    input wire logic de1_in,
    input wire logic ren1_n_in,
    input wire logic flip_in,
    output logic rx0_out,
    output logic rx1_out
);
    logic toggle_q = 1'b0;
    int cnt_q = 0;
    // Fail-safe bias holds an undriven cable at mark.
    wire cable = de0_in ? tx0_in : (de1_in ? tx1_in : 1'b1);
    wire line = cable ^ (flip_in && cnt_q > BIT_CYCLES && cnt_q <= 2 * BIT_CYCLES);
    always @(posedge clock_in) begin
        toggle_q <= ~toggle_q;
        if (cnt_q != 0 || !cable) begin
            cnt_q <= (cnt_q >= 9 * BIT_CYCLES + 4) ? 0 : cnt_q + 1;
        end
    end
    // A disabled receiver floats, so its output wanders instead of holding.
    assign rx0_out = ren0_n_in ? toggle_q : line;
    assign rx1_out = ren1_n_in ? toggle_q : line;
endmodule : rlt_cable_model

/* File: tb/rlt_loopback_tester_tb.sv */
// Self-checking bench for the loopback tester.
`timescale 1ns/1ps
`define RLT_CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module rlt_loopback_tester_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic flip = 1'b0;
    logic [15:0] rdata;
    logic tx0, de0, ren0, rx0, tx1, de1, ren1, rx1;
    logic [7:0] b0, b1;
    int errors = 0;
    int num_checks = 0;
    wire [5:0] ports = {tx0, de0, ren0, tx1, de1, ren1};
    always #2.5 clk = ~clk;
    rlt_loopback_tester #(.BIT_CYCLES(8)) u_dut (.clock_in(clk), .rst_n_in(rst_n),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .port0_line_tx_out(tx0), .port0_driver_enable_out(de0),
        .port0_receiver_enable_n_out(ren0), .port0_line_rx_in(rx0),
        .port1_line_tx_out(tx1), .port1_driver_enable_out(de1),
        .port1_receiver_enable_n_out(ren1), .port1_line_rx_in(rx1));
    rlt_cable_model #(.BIT_CYCLES(8)) u_cable (.clock_in(clk), .tx0_in(tx0), .de0_in(de0),
        .ren0_n_in(ren0), .tx1_in(tx1), .de1_in(de1), .ren1_n_in(ren1), .flip_in(flip),
        .rx0_out(rx0), .rx1_out(rx1));
    task automatic summarize();
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [15:0] ex);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `RLT_CHECK("rdata", ex, rdata)
        @(posedge clk);
    endtask : reg_read
    // Decodes one frame from the chosen port at bit centres; ends one edge past mid-stop.
    task automatic grab(input bit p, input logic [5:0] ex, output logic [7:0] b);
        logic [9:0] f;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
            if (n > 400) begin
                errors++;
                summarize();
            end
        end while ((p ? tx1 : tx0) !== 1'b0);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            #1 f[i] = p ? tx1 : tx0;
            if (i < 9) repeat (8) @(posedge clk);
        end
        b = f[8:1];
        `RLT_CHECK("frame", {2'h2, ex}, {f[9], f[0], ports})
        @(posedge clk);
    endtask : grab
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 `RLT_CHECK("reset ports", 6'h2D, ports)
        @(posedge clk);
        reg_read(8'h0A, 16'h0000);
        reg_write(8'h0A, 16'h0001);
        grab(1'b0, 6'h3C, b0);
        `RLT_CHECK("first byte", 8'h00, b0)
        grab(1'b0, 6'h3C, b1);
        `RLT_CHECK("next byte", b0 + 8'h01, b1)
        reg_write(8'h0B, 16'h0000);
        grab(1'b0, 6'h3C, b0);
        `RLT_CHECK("still running", b1 + 8'h01, b0)
        reg_read(8'h0A, 16'h0000);
        reg_write(8'h0A, 16'h0003);
        grab(1'b1, 6'h27, b0);
        grab(1'b1, 6'h27, b1);
        `RLT_CHECK("port1 byte", b0 + 8'h01, b1)
        flip <= 1'b1;
        grab(1'b1, 6'h27, b0);
        repeat (4) @(posedge clk);
        flip <= 1'b0;
        reg_read(8'h0A, 16'h0001);
        grab(1'b1, 6'h27, b0);
        grab(1'b1, 6'h27, b1);
        reg_read(8'h0A, 16'h0001);
        reg_read(8'h0B, 16'h0000);
        reg_write(8'h0A, 16'h0000);
        repeat (2) @(posedge clk);
        #1 `RLT_CHECK("stopped ports", 6'h2D, ports)
        @(posedge clk);
        reg_read(8'h0A, 16'h0001);
        reg_write(8'h0A, 16'h0001);
        grab(1'b0, 6'h3C, b0);
        repeat (4) @(posedge clk);
        reg_read(8'h0A, 16'h0000);
        summarize();
    end
endmodule : rlt_loopback_tester_tb
